// ---- logic/pac_top.sv ----
// Align and join control of a six channel 8-bit modulator, AHB-Lite slave.
// Assumes inputs synchronous to hclk; scaled clock ticks come from outside.
//
// Implementation choice: register access over AHB-Lite.
module pac_top
    import pac_pkg::*;
#(
    parameter int HADDR_W = 32
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [HADDR_W-1:0] haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire pac_mode_t          mode,
    input  wire logic               scale_tick_a,
    input  wire logic               scale_tick_b,
    output logic                    clock_a_tick,
    output logic                    clock_b_tick,
    output logic      [NCH-1:0]     modulator_output_port
);

    if (HADDR_W < 10) begin : g_chk
        $error("HADDR_W must be at least 10");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [7:0] rd_reg(input pac_regs_t r, input logic [7:0] i,
                                          input logic spec);
        logic [7:0] v;
        v = RST_ZERO;
        if (i == IDX_ENABLE) begin
            v = r.en;
        end else if (i == IDX_POLARITY) begin
            v = r.pol;
        end else if (i == IDX_CLKSEL) begin
            v = r.clksel;
        end else if (i == IDX_PRESCALE) begin
            v = r.prclk;
        end else if (i == IDX_CAE) begin
            v = r.cae;
        end else if (i == IDX_CTL) begin
            v = r.ctl;
        end else if (i == IDX_TEST) begin
            v = spec ? r.tst : RST_ZERO;
        end else if (i == IDX_PRSC_TEST) begin
            v = spec ? r.prsc : RST_ZERO;
        end else if (i >= IDX_PER0 && i < IDX_PER0 + 8'(NCH)) begin
            v = r.per[3'(i - IDX_PER0)];
        end else if (i >= IDX_DTY0 && i < IDX_DTY0 + 8'(NCH)) begin
            v = r.dty[3'(i - IDX_DTY0)];
        end
        return v;
    endfunction

    // Prescaler tap: tick when the low sel bits are all ones
    function automatic logic pre_tap(input logic [PRE_W-1:0] p, input logic [2:0] sel);
        logic [PRE_W-1:0] m;
        m = PRE_W'((8'h01 << sel) - 8'h01);
        return (p & m) == m;
    endfunction

    // Next {down, count} of one counter, 8 or 16 bits wide
    function automatic logic [16:0] step(input logic [15:0] c, input logic dn,
                                         input logic [15:0] p, input logic ca);
        logic [16:0] n;
        n = {1'b0, c + 16'h0001};
        if (p == 16'h0000) begin
            n = 17'h0;
        end else if (!ca) begin
            if (c >= p - 16'h0001) begin
                n = 17'h0;
            end
        end else if (dn) begin
            n = (c <= 16'h0001) ? 17'h0 : {1'b1, c - 16'h0001};
        end else if (c >= p) begin
            n = {1'b1, c - 16'h0001};
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    pac_state_t s, n;
    logic       run;
    logic [NCH-1:0] tk;
    logic       req;
    logic       mapped;

    assign req = hsel && hready && htrans[1];
    assign mapped = (haddr[HADDR_W-1:10] == '0) && (haddr[1:0] == 2'b00);

    always_comb begin
        logic [16:0] nx;
        logic [15:0] c16;
        logic [15:0] p16;
        logic [15:0] d16;
        int hi;
        int lo;
        nx = 17'h0;
        c16 = 16'h0;
        p16 = 16'h0;
        d16 = 16'h0;
        hi = 0;
        lo = 0;
        n = s;

        // Data phase of a write
        if (s.wr_pend) begin
            if (s.widx == IDX_ENABLE) begin
                n.r.en = hwdata[7:0] & MASK_CH;
            end else if (s.widx == IDX_POLARITY) begin
                n.r.pol = hwdata[7:0] & MASK_CH;
            end else if (s.widx == IDX_CLKSEL) begin
                n.r.clksel = hwdata[7:0] & MASK_CH;
            end else if (s.widx == IDX_PRESCALE) begin
                n.r.prclk = hwdata[7:0] & MASK_PRCLK;
            end else if (s.widx == IDX_CAE) begin
                n.r.cae = hwdata[7:0] & MASK_CH;
            end else if (s.widx == IDX_CTL) begin
                n.r.ctl = hwdata[7:0] & MASK_CTL;
            end else if (s.widx == IDX_TEST) begin
                if (mode.special_mode) begin
                    n.r.tst = hwdata[7:0];
                end
            end else if (s.widx == IDX_PRSC_TEST) begin
                if (mode.special_mode) begin
                    n.r.prsc = hwdata[7:0];
                end
            end else if (s.widx >= IDX_PER0 && s.widx < IDX_PER0 + 8'(NCH)) begin
                n.r.per[3'(s.widx - IDX_PER0)] = hwdata[7:0];
            end else if (s.widx >= IDX_DTY0 && s.widx < IDX_DTY0 + 8'(NCH)) begin
                n.r.dty[3'(s.widx - IDX_DTY0)] = hwdata[7:0];
            end
        end

        // Address phase; read sees a write still in its data phase
        n.wr_pend = req && hwrite && mapped;
        n.widx = haddr[9:2];
        if (req && !hwrite && mapped) begin
            n.rdata = {24'h0, rd_reg(n.r, haddr[9:2], mode.special_mode)};
        end else if (req) begin
            n.rdata = 32'h0;
        end
        n.ready = 1'b1;

        // Prescaler input clock gating
        if (run) begin
            n.pre = s.pre + PRE_W'(1);
        end
        n.tick_a = run && pre_tap(s.pre, s.r.prclk[CLOCK_A_PRESCALE_SELECT_LSB +: 3]);
        n.tick_b = run && pre_tap(s.pre, s.r.prclk[PCKB_LSB +: 3]);

        // Channel pairs
        for (int p = 0; p < NCH / 2; p++) begin
            hi = 2 * p;
            lo = 2 * p + 1;
            if (s.r.ctl[BIT_JOIN01 + p]) begin
                c16 = {s.cnt[hi], s.cnt[lo]};
                p16 = {s.r.per[hi], s.r.per[lo]};
                d16 = {s.r.dty[hi], s.r.dty[lo]};
                if (s.r.en[lo] && tk[lo]) begin
                    nx = step(c16, s.down[lo], p16, s.r.cae[lo]);
                    {n.down[lo], n.cnt[hi], n.cnt[lo]} = nx;
                end
                n.down[hi] = 1'b0;
                n.out[lo] = s.r.en[lo] && ((c16 < d16) == s.r.pol[lo]);
                n.out[hi] = 1'b0;
            end else begin
                for (int k = hi; k <= lo; k++) begin
                    if (s.r.en[k] && tk[k]) begin
                        nx = step({8'h0, s.cnt[k]}, s.down[k], {8'h0, s.r.per[k]},
                                  s.r.cae[k]);
                        n.down[k] = nx[16];
                        n.cnt[k] = nx[7:0];
                    end
                    n.out[k] = s.r.en[k] && ((s.cnt[k] < s.r.dty[k]) == s.r.pol[k]);
                end
            end
        end
    end

    // Gated prescaler input and per-channel clock enables
    assign run = !(mode.wait_mode && s.r.ctl[BIT_WAIT])
              && !(mode.freeze_mode && s.r.ctl[BIT_FRZ]);

    always_comb begin
        for (int k = 0; k < NCH; k++) begin
            if (k == 2 || k == 3) begin
                tk[k] = s.r.clksel[k] ? (scale_tick_b && run) : s.tick_b;
            end else begin
                tk[k] = s.r.clksel[k] ? (scale_tick_a && run) : s.tick_a;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.r.per <= {NCH{RST_PER}};
            s.r.dty <= {NCH{RST_DTY}};
            s.ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hrdata = s.rdata;
    assign hreadyout = s.ready;
    assign hresp = HRESP_OKAY;
    assign clock_a_tick = s.tick_a;
    assign clock_b_tick = s.tick_b;
    assign modulator_output_port = s.out;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence rd_test_normal;
        req && !hwrite && mapped && !mode.special_mode
            && (haddr[9:2] == IDX_TEST || haddr[9:2] == IDX_PRSC_TEST);
    endsequence

    a_test_read_zero: assert property (rd_test_normal |=> hrdata == 32'h0)
        else $error("test register read not zero");

    a_test_write_ignored: assert property (
        s.wr_pend && !mode.special_mode |=> $stable(s.r.tst) && $stable(s.r.prsc))
        else $error("test register written in normal mode");

    a_wait_gate: assert property (
        mode.wait_mode && s.r.ctl[BIT_WAIT] |=> s.pre == $past(s.pre) && !s.tick_a)
        else $error("prescaler ran in wait mode");

    a_freeze_gate: assert property (
        mode.freeze_mode && s.r.ctl[BIT_FRZ] |=> s.pre == $past(s.pre) && !s.tick_b)
        else $error("prescaler ran in freeze mode");

    a_clock_resume: assert property (
        !(mode.freeze_mode && s.r.ctl[BIT_FRZ]) && !(mode.wait_mode && s.r.ctl[BIT_WAIT])
            |=> s.pre == PRE_W'($past(s.pre) + PRE_W'(1)))
        else $error("prescaler did not resume");

    a_ratio_128: assert property (
        run && s.r.prclk[CLOCK_A_PRESCALE_SELECT_LSB +: 3] == 3'h7 |=> s.tick_a == ($past(s.pre) == 7'h7f))
        else $error("clock A divide by 128 wrong");

    a_left_wrap: assert property (
        s.r.en[0] && !s.r.cae[0] && !s.r.ctl[BIT_JOIN01] && tk[0] && !s.wr_pend
            && s.r.per[0] != 8'h00 && s.cnt[0] == s.r.per[0] - 8'h01
            |=> s.cnt[0] == 8'h00 && !s.down[0])
        else $error("left aligned counter did not wrap");

    a_center_turn: assert property (
        s.r.en[0] && s.r.cae[0] && !s.r.ctl[BIT_JOIN01] && tk[0] && !s.down[0]
            && s.r.per[0] > 8'h01 && s.cnt[0] == s.r.per[0] && !s.wr_pend
            |=> s.down[0] && s.cnt[0] == $past(s.cnt[0]) - 8'h01)
        else $error("center aligned counter did not turn");

    a_joined_carry: assert property (
        s.r.ctl[BIT_JOIN01] && s.r.en[1] && !s.r.cae[1] && tk[1] && !s.wr_pend
            && s.cnt[1] == 8'hff && {s.cnt[0], s.cnt[1]} < {s.r.per[0], s.r.per[1]} - 16'h1
            |=> s.cnt[1] == 8'h00 && s.cnt[0] == $past(s.cnt[0]) + 8'h01)
        else $error("joined counter did not carry");

    a_high_quiet: assert property (
        s.r.ctl[BIT_JOIN01 + 2] |=> !modulator_output_port[4])
        else $error("high channel of joined pair drove output");

endmodule

// ---- logic/pac_pkg.sv ----
// Constants and carriers for the modulator align and join control block.
// Assumes a single bus clock and AHB-Lite register access.
package pac_pkg;

    localparam int NCH = 6;
    localparam int PRE_W = 7;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_ENABLE    = 8'h00;
    localparam logic [7:0] IDX_POLARITY  = 8'h01;
    localparam logic [7:0] IDX_CLKSEL    = 8'h02;
    localparam logic [7:0] IDX_PRESCALE  = 8'h03;
    localparam logic [7:0] IDX_CAE       = 8'h04;
    localparam logic [7:0] IDX_CTL       = 8'h05;
    localparam logic [7:0] IDX_TEST      = 8'h06;
    localparam logic [7:0] IDX_PRSC_TEST = 8'h07;
    localparam logic [7:0] IDX_PER0      = 8'h14;
    localparam logic [7:0] IDX_DTY0      = 8'h1a;

    // Control and prescale register fields
    localparam int BIT_JOIN01 = 4;
    localparam int BIT_WAIT   = 3;
    localparam int BIT_FRZ    = 2;
    localparam int CLOCK_A_PRESCALE_SELECT_LSB   = 0;
    localparam int PCKB_LSB   = 4;

    // Writable bit masks
    localparam logic [7:0] MASK_CH    = 8'h3f;
    localparam logic [7:0] MASK_CTL   = 8'h7c;
    localparam logic [7:0] MASK_PRCLK = 8'h77;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PER  = 8'hff;
    localparam logic [7:0] RST_DTY  = 8'hff;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef struct packed {
        logic wait_mode;
        logic freeze_mode;
        logic special_mode;
    } pac_mode_t;

    typedef struct packed {
        logic [7:0]            en;
        logic [7:0]            pol;
        logic [7:0]            clksel;
        logic [7:0]            prclk;
        logic [7:0]            cae;
        logic [7:0]            ctl;
        logic [7:0]            tst;
        logic [7:0]            prsc;
        logic [NCH-1:0][7:0]   per;
        logic [NCH-1:0][7:0]   dty;
    } pac_regs_t;

    typedef struct packed {
        pac_regs_t             r;
        logic [NCH-1:0][7:0]   cnt;
        logic [NCH-1:0]        down;
        logic [PRE_W-1:0]      pre;
        logic                  tick_a;
        logic                  tick_b;
        logic                  wr_pend;
        logic [7:0]            widx;
        logic [31:0]           rdata;
        logic                  ready;
        logic [NCH-1:0]        out;
    } pac_state_t;

endpackage

// ---- verif/pac_top_bench.sv ----
// Self-checking bench for pac_top: register access, alignment, pair joining
// and prescaler stop in wait and freeze modes.
// Assumes pac_top is the only bus slave, so hready is its own hreadyout.
module pac_top_bench
    import pac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic               hclk;
    logic               hresetn;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    wire logic          hready;
    wire logic [31:0]   hrdata;
    wire logic          hreadyout;
    wire logic          hresp;
    pac_mode_t          mode;
    logic               scale_tick_a;
    logic               scale_tick_b;
    wire logic          clock_a_tick;
    wire logic          clock_b_tick;
    wire logic [NCH-1:0] modulator_output_port;
    int                 num_errors;
    int                 cmp_count;

    assign hready = hreadyout;

    pac_top pac_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mode(mode), .scale_tick_a(scale_tick_a), .scale_tick_b(scale_tick_b),
        .clock_a_tick(clock_a_tick), .clock_b_tick(clock_b_tick),
        .modulator_output_port(modulator_output_port)
    );

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: bus wait timed out", $time);
            end_sim();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, d, rd);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, rd);
        chk(rd, exp);
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    task automatic settle;
        repeat (4) @(posedge hclk);
    endtask

    task automatic watch(input int ch, input int n, output int rises, output int highs);
        logic prev;
        rises = 0;
        highs = 0;
        @(posedge hclk);
        prev = modulator_output_port[ch];
        repeat (n) begin
            @(posedge hclk);
            if (modulator_output_port[ch] === 1'b1) begin
                highs++;
                if (prev !== 1'b1) rises++;
            end
            prev = modulator_output_port[ch];
        end
    endtask

    task automatic ticks(input int n, output int t);
        t = 0;
        repeat (n) begin
            @(posedge hclk);
            if (clock_a_tick === 1'b1) t++;
        end
    endtask

    task automatic ticks_b(input int n, output int t);
        t = 0;
        repeat (n) begin
            @(posedge hclk);
            if (clock_b_tick === 1'b1) t++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd_chk(IDX_CTL, 32'h0);
        rd_chk(IDX_CAE, 32'h0);
        rd_chk(IDX_DTY0 + 8'h05, 32'hff);
        rd_chk(IDX_TEST, 32'h0);
        wr(IDX_CTL, 8'hff);
        rd_chk(IDX_CTL, {24'h0, MASK_CTL});
        wr(IDX_CAE, 8'hff);
        rd_chk(IDX_CAE, {24'h0, MASK_CH});
        wr(IDX_TEST, 8'ha5);
        wr(IDX_PRSC_TEST, 8'h5a);
        rd_chk(IDX_TEST, 32'h0);
        rd_chk(IDX_PRSC_TEST, 32'h0);
        rd_chk(IDX_CTL, {24'h0, MASK_CTL});
        wr(8'h30, 8'hff);
        rd_chk(8'h30, 32'h0);
        mode.special_mode <= 1'b1;
        wr(IDX_TEST, 8'ha5);
        rd_chk(IDX_TEST, 32'ha5);
        mode.special_mode <= 1'b0;
        rd_chk(IDX_TEST, 32'h0);
        wr(IDX_CTL, 8'h00);
        wr(IDX_CAE, 8'h00);
    endtask

    task automatic t_align;
        int r;
        int h;
        for (int c = 0; c < 2; c++) begin
            wr(IDX_ENABLE, 8'h00);
            wr(IDX_CAE, 8'(c));
            wr(IDX_POLARITY, 8'h01);
            wr(IDX_PER0, 8'h04);
            wr(IDX_DTY0, 8'h02);
            wr(IDX_ENABLE, 8'h01);
            settle();
            watch(0, 64, r, h);
            chk(r, (c == 1) ? 8 : 16);
        end
        wr(IDX_ENABLE, 8'h00);
        wr(IDX_CAE, 8'h00);
    endtask

    task automatic t_join(input int k);
        int hc;
        int lc;
        int r;
        int h;
        hc = 2 * k;
        lc = hc + 1;
        wr(IDX_ENABLE, 8'h00);
        wr(IDX_CTL, 8'(8'h10 << k));
        wr(IDX_PER0 + 8'(hc), 8'h00);
        wr(IDX_PER0 + 8'(lc), 8'h08);
        wr(IDX_DTY0 + 8'(hc), 8'h01);
        wr(IDX_DTY0 + 8'(lc), 8'h00);
        wr(IDX_POLARITY, 8'(1 << lc));
        wr(IDX_ENABLE, 8'((1 << hc) | (1 << lc)));
        settle();
        watch(lc, 32, r, h);
        chk(h, 32);
        watch(hc, 32, r, h);
        chk(h, 0);
        wr(IDX_DTY0 + 8'(hc), 8'h00);
        wr(IDX_DTY0 + 8'(lc), 8'h04);
        settle();
        watch(lc, 64, r, h);
        chk(r, 8);
        // Period above 255 forces a carry from the low into the high byte
        wr(IDX_PER0 + 8'(hc), 8'h01);
        wr(IDX_DTY0 + 8'(hc), 8'h01);
        wr(IDX_DTY0 + 8'(lc), 8'h00);
        settle();
        watch(lc, 528, r, h);
        chk(h, 512);
        chk(r, 2);
        wr(IDX_ENABLE, 8'h00);
        wr(IDX_CTL, 8'h00);
        wr(IDX_ENABLE, 8'(1 << lc));
        settle();
        watch(lc, 32, r, h);
        chk(h, 0);
        wr(IDX_ENABLE, 8'h00);
    endtask

    task automatic t_stop;
        int t;
        wr(IDX_PRESCALE, 8'h01);
        settle();
        ticks(32, t);
        chk(t, 16);
        ticks_b(32, t);
        chk(t, 32);
        mode.wait_mode <= 1'b1;
        settle();
        ticks(32, t);
        chk(t, 16);
        wr(IDX_CTL, 8'h08);
        settle();
        ticks(32, t);
        chk(t, 0);
        mode.wait_mode <= 1'b0;
        settle();
        ticks(32, t);
        chk(t, 16);
        wr(IDX_CTL, 8'h04);
        mode.freeze_mode <= 1'b1;
        settle();
        ticks(32, t);
        chk(t, 0);
        ticks_b(32, t);
        chk(t, 0);
        rd_chk(IDX_CTL, 32'h04);
        wr(IDX_CTL, 8'h00);
        settle();
        ticks(32, t);
        chk(t, 16);
        wr(IDX_CTL, 8'h04);
        mode.freeze_mode <= 1'b0;
        settle();
        ticks(32, t);
        chk(t, 16);
        wr(IDX_PRESCALE, 8'h07);
        settle();
        ticks(256, t);
        chk(t, 2);
        wr(IDX_CTL, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        mode = '0;
        scale_tick_a = 1'b0;
        scale_tick_b = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_align();
        for (int k = 0; k < 3; k++) t_join(k);
        t_stop();
        end_sim();
    end
endmodule
